// File: hdl/frc_top.sv
// fault rollup, link fault flags and fault clear register behind an apb slave
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "frc_map.svh"
module frc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire frc_pkg::frc_group_faults_t group_faults,
  input wire frc_pkg::frc_link_events_t link_events,
  input wire logic [7:0] otp_fault_set,
  input wire logic active_mode,
  input wire logic sleep_mode,
  output logic fault_out_n,
  output logic [7:0] fault_rollup
);
  import frc_pkg::*;

  frc_state_t st_reg;
  frc_state_t st_next;

  logic setup_phase;
  logic commit;
  logic commit_write;
  logic [13:0] word_idx;
  logic aligned;
  logic hit;
  logic clear_link;
  logic clear_checksum;
  logic [7:0] link_set;
  logic [31:0] read_word;

  assign setup_phase = psel & ~penable;
  assign commit = psel & penable & st_reg.pready;
  assign commit_write = commit & pwrite;
  assign word_idx = paddr[15:2];
  assign aligned = (paddr[1:0] == 2'h0);

  always_comb begin
    st_next = st_reg;
    // address decode
    hit = 1'b1;
    read_word = 32'h0000_0000;
    case (word_idx)
      `FRC_IDX_CLEAR_TWO: read_word = 32'h0000_0000;
      `FRC_IDX_ROLLUP: read_word = {24'h00_0000, st_reg.summary};
      `FRC_IDX_LINK_FLAGS: read_word = {24'h00_0000, st_reg.link_flags};
      `FRC_IDX_OTP_FLAGS: read_word = {24'h00_0000, st_reg.otp_flags};
      `FRC_IDX_MASKS: read_word = {22'h00_0000, st_reg.masks};
      `FRC_IDX_RESP_DETAIL: read_word = {24'h00_0000, st_reg.resp_detail};
      `FRC_IDX_CMD_DETAIL: read_word = {24'h00_0000, st_reg.cmd_detail};
      default: hit = 1'b0;
    endcase
    hit = hit & aligned;

    // one wait-free access phase: answer prepared in the setup cycle
    st_next.pready = setup_phase;
    st_next.pslverr = setup_phase & ~hit;
    st_next.prdata = (setup_phase & ~pwrite & hit) ? read_word : 32'h0000_0000;

    // clear strobes self-clear, so the clear register reads zero
    clear_link = commit_write & hit & (word_idx == `FRC_IDX_CLEAR_TWO) & pwdata[`FRC_CLR_LINK_BIT];
    clear_checksum = commit_write & hit & (word_idx == `FRC_IDX_CLEAR_TWO)
      & pwdata[`FRC_CLR_OTP_CHECKSUM_BIT];

    if (commit_write & hit & (word_idx == `FRC_IDX_MASKS)) begin
      st_next.masks = pwdata[9:0];
    end

    // link fault events, set wins over clear
    link_set = 8'h00;
    link_set[`FRC_LINK_TX_BIT] = link_events.response_transmit_error;
    link_set[`FRC_LINK_RR_BIT] = link_events.response_receive_error;
    link_set[`FRC_LINK_RC_BIT] = link_events.command_receive_error;
    link_set[`FRC_LINK_CLEAR_BIT] = link_events.clear_pattern
      | (link_events.wake_ping & (active_mode | sleep_mode))
      | (link_events.wake_pin & active_mode);
    link_set[`FRC_LINK_STOP_BIT] = link_events.stop_pattern
      | (link_events.wake_ping & active_mode);
    st_next.link_flags = (clear_link ? `FRC_BYTE_RESET : st_reg.link_flags) | link_set;

    // detail capture, a fresh error wins over the clear
    if (link_events.response_transmit_error | link_events.response_receive_error) begin
      st_next.resp_detail = link_events.response_detail_in;
    end else if (clear_link) begin
      st_next.resp_detail = `FRC_BYTE_RESET;
    end
    if (link_events.command_receive_error) begin
      st_next.cmd_detail = link_events.command_detail_in;
    end else if (clear_link) begin
      st_next.cmd_detail = `FRC_BYTE_RESET;
    end

    // otp flags: only the two checksum bits are cleared here
    st_next.otp_flags = (st_reg.otp_flags & ~(clear_checksum ? `FRC_OTP_CHECKSUM_BITS : 8'h00))
      | otp_fault_set;

    // rollup recomputed every cycle from current state
    st_next.summary[7] = ~st_reg.masks[`FRC_MSK_PROTECTOR] & group_faults.protector_any;
    st_next.summary[6] = st_reg.masks[`FRC_MSK_ADC_COMPARE] & group_faults.adc_compare_any;
    st_next.summary[5] = ~st_reg.masks[`FRC_OTP_MASK] & (|st_reg.otp_flags);
    st_next.summary[4] = ~st_reg.masks[`FRC_MSK_LINK] & (|st_reg.link_flags);
    st_next.summary[3] = (~st_reg.masks[`FRC_MSK_OVERTEMP] & group_faults.overtemp_any)
      | (~st_reg.masks[`FRC_MSK_UNDERTEMP] & group_faults.undertemp_any);
    st_next.summary[2] = (~st_reg.masks[`FRC_MSK_OVERVOLTAGE] & group_faults.overvoltage_any)
      | (~st_reg.masks[`FRC_MSK_UNDERVOLTAGE] & group_faults.undervoltage_any);
    st_next.summary[1] = ~st_reg.masks[`FRC_MSK_SYSTEM] & group_faults.system_any;
    st_next.summary[0] = ~st_reg.masks[`FRC_MSK_POWER] & group_faults.power_any;
    st_next.fault_out_n = ~(|st_next.summary);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.summary <= `FRC_BYTE_RESET;
      st_reg.fault_out_n <= 1'b1;
      st_reg.link_flags <= `FRC_BYTE_RESET;
      st_reg.otp_flags <= `FRC_BYTE_RESET;
      st_reg.resp_detail <= `FRC_BYTE_RESET;
      st_reg.cmd_detail <= `FRC_BYTE_RESET;
      st_reg.masks <= `FRC_MASKS_RESET;
      st_reg.pready <= 1'b0;
      st_reg.pslverr <= 1'b0;
      st_reg.prdata <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign fault_out_n = st_reg.fault_out_n;
  assign fault_rollup = st_reg.summary;

  // checks
  logic clr_write_seen;
  assign clr_write_seen = commit_write & aligned & (word_idx == `FRC_IDX_CLEAR_TWO);

  property p_checksum_clear;
    @(posedge pclk) disable iff (!presetn)
    (clr_write_seen && pwdata[6] && otp_fault_set == 8'h00)
      |=> (st_reg.otp_flags == ($past(st_reg.otp_flags) & 8'he7));
  endproperty
  a_checksum_clear: assert property (p_checksum_clear) else $error("checksum clear wrong");

  property p_link_clear;
    @(posedge pclk) disable iff (!presetn)
    (clr_write_seen && pwdata[0] && link_set == 8'h00 && !link_events.response_transmit_error
      && !link_events.response_receive_error && !link_events.command_receive_error)
      |=> (st_reg.link_flags == 8'h00 && st_reg.resp_detail == 8'h00 && st_reg.cmd_detail == 8'h00);
  endproperty
  a_link_clear: assert property (p_link_clear) else $error("link clear wrong");

  property p_zero_write_keeps;
    @(posedge pclk) disable iff (!presetn)
    (clr_write_seen && !pwdata[0]) |=> ((st_reg.link_flags & $past(st_reg.link_flags)) == $past(st_reg.link_flags));
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("zero write cleared flags");

  property p_pin_mirror;
    @(posedge pclk) disable iff (!presetn)
    fault_out_n == !(|fault_rollup);
  endproperty
  a_pin_mirror: assert property (p_pin_mirror) else $error("pin and rollup disagree");

  property p_protector;
    @(posedge pclk) disable iff (!presetn)
    (group_faults.protector_any && !st_reg.masks[0]) |=> fault_rollup[7];
  endproperty
  a_protector: assert property (p_protector) else $error("protector bit missing");

  property p_adc_compare;
    @(posedge pclk) disable iff (!presetn)
    !(st_reg.masks[1] && group_faults.adc_compare_any) |=> !fault_rollup[6];
  endproperty
  a_adc_compare: assert property (p_adc_compare) else $error("compare bit set wrongly");

  property p_otp_group;
    @(posedge pclk) disable iff (!presetn)
    ##1 fault_rollup[5] == $past(!st_reg.masks[2] && (|st_reg.otp_flags));
  endproperty
  a_otp_group: assert property (p_otp_group) else $error("otp bit wrong");

  property p_link_pin;
    @(posedge pclk) disable iff (!presetn)
    ((|st_reg.link_flags) && !st_reg.masks[3]) |=> (fault_rollup[4] && !fault_out_n);
  endproperty
  a_link_pin: assert property (p_link_pin) else $error("link fault not on pin");

  property p_temperature;
    @(posedge pclk) disable iff (!presetn)
    (group_faults.undertemp_any && !st_reg.masks[5]) |=> fault_rollup[3];
  endproperty
  a_temperature: assert property (p_temperature) else $error("temperature bit missing");

  property p_voltage;
    @(posedge pclk) disable iff (!presetn)
    (!group_faults.overvoltage_any && !group_faults.undervoltage_any) |=> !fault_rollup[2];
  endproperty
  a_voltage: assert property (p_voltage) else $error("voltage bit set wrongly");

  property p_system;
    @(posedge pclk) disable iff (!presetn)
    (group_faults.system_any && st_reg.masks[8]) |=> !fault_rollup[1];
  endproperty
  a_system: assert property (p_system) else $error("masked system fault shown");

  property p_power;
    @(posedge pclk) disable iff (!presetn)
    (group_faults.power_any && !st_reg.masks[9]) |=> fault_rollup[0];
  endproperty
  a_power: assert property (p_power) else $error("power bit missing");

  property p_tx_error;
    @(posedge pclk) disable iff (!presetn)
    link_events.response_transmit_error
      |=> (st_reg.link_flags[4] && st_reg.resp_detail == $past(link_events.response_detail_in));
  endproperty
  a_tx_error: assert property (p_tx_error) else $error("transmit error not recorded");

  property p_rr_error;
    @(posedge pclk) disable iff (!presetn)
    link_events.response_receive_error |=> st_reg.link_flags[3];
  endproperty
  a_rr_error: assert property (p_rr_error) else $error("response receive error lost");

  property p_rc_error;
    @(posedge pclk) disable iff (!presetn)
    link_events.command_receive_error
      |=> (st_reg.link_flags[2] && st_reg.cmd_detail == $past(link_events.command_detail_in));
  endproperty
  a_rc_error: assert property (p_rc_error) else $error("command error not recorded");

  property p_clear_seen;
    @(posedge pclk) disable iff (!presetn)
    (link_events.clear_pattern || (link_events.wake_pin && active_mode)) |=> st_reg.link_flags[1];
  endproperty
  a_clear_seen: assert property (p_clear_seen) else $error("clear pattern lost");

  property p_wake_sleep;
    @(posedge pclk) disable iff (!presetn)
    (link_events.wake_ping && sleep_mode) |=> st_reg.link_flags[1];
  endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("wake ping not flagged");

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
    (link_events.stop_pattern || (link_events.wake_ping && active_mode)) |=> st_reg.link_flags[0];
  endproperty
  a_stop: assert property (p_stop) else $error("stop flag lost");

  property p_stop_sleep;
    @(posedge pclk) disable iff (!presetn)
    (clr_write_seen && pwdata[0] && !link_events.stop_pattern && !active_mode) |=> !st_reg.link_flags[0];
  endproperty
  a_stop_sleep: assert property (p_stop_sleep) else $error("stop flag set outside active");

  property p_link_masked;
    @(posedge pclk) disable iff (!presetn)
    st_reg.masks[3] |=> !fault_rollup[4];
  endproperty
  a_link_masked: assert property (p_link_masked) else $error("masked link fault on pin");

  property p_recompute;
    @(posedge pclk) disable iff (!presetn)
    (group_faults == '0 && st_reg.link_flags == 8'h00 && st_reg.otp_flags == 8'h00) |=> fault_out_n;
  endproperty
  a_recompute: assert property (p_recompute) else $error("pin stuck after faults gone");

  property p_answer;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> (pready ##1 !pready);
  endproperty
  a_answer: assert property (p_answer) else $error("apb answer timing wrong");

  // other side of each group bit, storage and bus checks
  property p_adc_set;
    @(posedge pclk) disable iff (!presetn)
    (group_faults.adc_compare_any && st_reg.masks[1]) |=> fault_rollup[6];
  endproperty
  a_adc_set: assert property (p_adc_set) else $error("compare bit missing");

  property p_protector_masked;
    @(posedge pclk) disable iff (!presetn)
    st_reg.masks[0] |=> !fault_rollup[7];
  endproperty
  a_protector_masked: assert property (p_protector_masked) else $error("masked protector fault shown");

  property p_overtemp;
    @(posedge pclk) disable iff (!presetn)
    (group_faults.overtemp_any && !st_reg.masks[4]) |=> fault_rollup[3];
  endproperty
  a_overtemp: assert property (p_overtemp) else $error("overtemperature bit missing");

  property p_temp_quiet;
    @(posedge pclk) disable iff (!presetn)
    (!group_faults.overtemp_any && !group_faults.undertemp_any) |=> !fault_rollup[3];
  endproperty
  a_temp_quiet: assert property (p_temp_quiet) else $error("temperature bit set wrongly");

  property p_overvoltage;
    @(posedge pclk) disable iff (!presetn)
    (group_faults.overvoltage_any && !st_reg.masks[6]) |=> fault_rollup[2];
  endproperty
  a_overvoltage: assert property (p_overvoltage) else $error("overvoltage bit missing");

  property p_undervoltage;
    @(posedge pclk) disable iff (!presetn)
    (group_faults.undervoltage_any && !st_reg.masks[7]) |=> fault_rollup[2];
  endproperty
  a_undervoltage: assert property (p_undervoltage) else $error("undervoltage bit missing");

  property p_system_set;
    @(posedge pclk) disable iff (!presetn)
    (group_faults.system_any && !st_reg.masks[8]) |=> fault_rollup[1];
  endproperty
  a_system_set: assert property (p_system_set) else $error("system bit missing");

  property p_power_masked;
    @(posedge pclk) disable iff (!presetn)
    st_reg.masks[9] |=> !fault_rollup[0];
  endproperty
  a_power_masked: assert property (p_power_masked) else $error("masked power fault shown");

  property p_rr_detail;
    @(posedge pclk) disable iff (!presetn)
    link_events.response_receive_error |=> (st_reg.resp_detail == $past(link_events.response_detail_in));
  endproperty
  a_rr_detail: assert property (p_rr_detail) else $error("response detail not recorded");

  property p_link_sticky;
    @(posedge pclk) disable iff (!presetn)
    !clear_link |=> ((st_reg.link_flags & $past(st_reg.link_flags)) == $past(st_reg.link_flags));
  endproperty
  a_link_sticky: assert property (p_link_sticky) else $error("link flag dropped without clear");

  property p_otp_keep;
    @(posedge pclk) disable iff (!presetn)
    !clear_checksum |=> ((st_reg.otp_flags & $past(st_reg.otp_flags)) == $past(st_reg.otp_flags));
  endproperty
  a_otp_keep: assert property (p_otp_keep) else $error("otp flag dropped without clear");

  property p_otp_set;
    @(posedge pclk) disable iff (!presetn)
    (otp_fault_set != 8'h00) |=> ((st_reg.otp_flags & $past(otp_fault_set)) == $past(otp_fault_set));
  endproperty
  a_otp_set: assert property (p_otp_set) else $error("otp flag not captured");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !hit) |=> (pready && pslverr);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_idle_bus;
    @(posedge pclk) disable iff (!presetn)
    !pready |-> (prdata == 32'h0000_0000 && !pslverr);
  endproperty
  a_idle_bus: assert property (p_idle_bus) else $error("bus answer outside ready");

  property p_mask_write;
    @(posedge pclk) disable iff (!presetn)
    (commit_write && hit && word_idx == `FRC_IDX_MASKS) |=> (st_reg.masks == $past(pwdata[9:0]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_rollup_read;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && aligned && word_idx == `FRC_IDX_ROLLUP)
      |=> (prdata == {24'h00_0000, $past(st_reg.summary)});
  endproperty
  a_rollup_read: assert property (p_rollup_read) else $error("rollup read data wrong");
endmodule
`default_nettype wire

// File: hdl/frc_map.svh
// register offsets, field positions and reset values of the fault rollup block
// Notes on behaviour
// - writing 1 to bit 6 of clear register zeroes only both checksum error flags
// - writing 1 to bit 0 zeroes link fault flags and both detail registers; 0 does nothing
// - read-only rollup register mirrors the fault pin state, resetting to zero
// - rollup bit 7 set when protector mask is 0 and a protector fault is present
// - rollup bit 6 set when compare mask is 1 and a compare fault is present
// - rollup bit 5 set when otp mask is 0 and any otp fault flag is set
// - rollup bit 4 set when link mask is 0 and any link fault flag is set
// - rollup bit 3 from unmasked overtemperature or undertemperature faults
// - rollup bit 2 from unmasked overvoltage or undervoltage faults
// - rollup bit 1 set when system mask is 0 and a system fault is present
// - rollup bit 0 set when power mask is 0 and a power rail fault is present
// - response transmit error sets link flag bit 4 and captures response detail
// - response receive error sets link flag bit 3 and captures response detail
// - command receive error sets link flag bit 2 and captures command detail
// - link clear pattern on receive line sets link flag bit 1
// - wake ping in active or sleep, or wake pin in active, also sets bit 1
// - unexpected stop condition sets link flag bit 0
// - wake ping seen while already active also sets bit 0
// - unmasked link fault flags drive the fault pin low; masked ones leave it alone
`ifndef FRC_MAP_SVH
`define FRC_MAP_SVH
`define FRC_IDX_CLEAR_TWO 14'h0332
`define FRC_IDX_ROLLUP 14'h052d
`define FRC_IDX_LINK_FLAGS 14'h0530
`define FRC_IDX_OTP_FLAGS 14'h0535
`define FRC_IDX_MASKS 14'h0600
`define FRC_IDX_RESP_DETAIL 14'h0601
`define FRC_IDX_CMD_DETAIL 14'h0602
`define FRC_CLR_OTP_CHECKSUM_BIT 6
`define FRC_CLR_LINK_BIT 0
`define FRC_OTP_CHECKSUM_BITS 8'h18
`define FRC_LINK_TX_BIT 4
`define FRC_LINK_RR_BIT 3
`define FRC_LINK_RC_BIT 2
`define FRC_LINK_CLEAR_BIT 1
`define FRC_LINK_STOP_BIT 0
`define FRC_MSK_PROTECTOR 0
`define FRC_MSK_ADC_COMPARE 1
`define FRC_OTP_MASK 2
`define FRC_MSK_LINK 3
`define FRC_MSK_OVERTEMP 4
`define FRC_MSK_UNDERTEMP 5
`define FRC_MSK_OVERVOLTAGE 6
`define FRC_MSK_UNDERVOLTAGE 7
`define FRC_MSK_SYSTEM 8
`define FRC_MSK_POWER 9
`define FRC_MASKS_RESET 10'h000
`define FRC_BYTE_RESET 8'h00
`endif

// File: hdl/frc_pkg.sv
// types of the fault rollup block
package frc_pkg;
  typedef struct packed {
    logic protector_any;
    logic adc_compare_any;
    logic overtemp_any;
    logic undertemp_any;
    logic overvoltage_any;
    logic undervoltage_any;
    logic system_any;
    logic power_any;
  } frc_group_faults_t;
  typedef struct packed {
    logic response_transmit_error;
    logic response_receive_error;
    logic command_receive_error;
    logic clear_pattern;
    logic stop_pattern;
    logic wake_ping;
    logic wake_pin;
    logic [7:0] response_detail_in;
    logic [7:0] command_detail_in;
  } frc_link_events_t;
  typedef struct packed {
    logic [7:0] summary;
    logic fault_out_n;
    logic [7:0] link_flags;
    logic [7:0] otp_flags;
    logic [7:0] resp_detail;
    logic [7:0] cmd_detail;
    logic [9:0] masks;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } frc_state_t;
endpackage

// File: tb/frc_link_model.sv
// link event source standing in for the uart receiver and transmitter side
`timescale 1ns/1ps
`default_nettype none
module frc_link_model import frc_pkg::*; (
  input wire logic pclk,
  output var frc_pkg::frc_link_events_t ev
);
  initial ev = '0;
  // kind 0..6: tx, rr, rc, clear, stop, wake ping, wake pin; one-cycle pulse
  task automatic fire(input int kind, input logic [7:0] det);
    @(posedge pclk);
    ev <= frc_link_events_t'({7'h40 >> kind, det, det});
    @(posedge pclk);
    ev <= '0;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the fault rollup block
`timescale 1ns/1ps
`default_nettype none
`include "frc_map.svh"
module tb;
  import frc_pkg::*;
  localparam logic [15:0] A_CLR = {`FRC_IDX_CLEAR_TWO, 2'b00};
  localparam logic [15:0] A_ROL = {`FRC_IDX_ROLLUP, 2'b00};
  localparam logic [15:0] A_LNK = {`FRC_IDX_LINK_FLAGS, 2'b00};
  localparam logic [15:0] A_OTP = {`FRC_IDX_OTP_FLAGS, 2'b00};
  localparam logic [15:0] A_MSK = {`FRC_IDX_MASKS, 2'b00};
  localparam logic [15:0] A_RSP = {`FRC_IDX_RESP_DETAIL, 2'b00};
  localparam logic [15:0] A_CMD = {`FRC_IDX_CMD_DETAIL, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fault_out_n, active_mode, sleep_mode, re;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [7:0] fault_rollup, otp_fault_set;
  frc_group_faults_t group_faults;
  frc_link_events_t link_events;
  int err_total, cmp_count, cycles;
  frc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .group_faults(group_faults), .link_events(link_events), .otp_fault_set(otp_fault_set),
    .active_mode(active_mode), .sleep_mode(sleep_mode), .fault_out_n(fault_out_n),
    .fault_rollup(fault_rollup));
  frc_link_model link (.pclk(pclk), .ev(link_events));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      wrap_up;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [15:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task t_reset;
    chk(fault_rollup, 32'h0);
    chk(fault_out_n, 32'h1);
    rd(A_ROL);
    chk(rv, 32'h0);
    rd(A_LNK);
    chk(rv, 32'h0);
  endtask
  task automatic t_groups;
    logic [7:0] sb [8] = '{8'h80, 8'h40, 8'h08, 8'h08, 8'h04, 8'h04, 8'h02, 8'h01};
    int mb [8] = '{0, 1, 4, 5, 6, 7, 8, 9};
    logic [7:0] ex;
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      group_faults <= frc_group_faults_t'(8'h80 >> i);
      wt(3);
      ex = (i == 1) ? 8'h00 : sb[i];
      chk(fault_rollup, ex);
      chk(fault_out_n, ex == 0);
      wr(A_MSK, 32'h1 << mb[i]);
      wt(2);
      ex = (i == 1) ? sb[i] : 8'h00;
      rd(A_ROL);
      chk(rv, ex);
      wr(A_MSK, 32'h0);
      group_faults <= '0;
      wt(3);
      chk(fault_rollup, 32'h0);
    end
  endtask
  task automatic t_link;
    logic [7:0] ex [7] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h03, 8'h02};
    for (int k = 0; k < 7; k++) begin
      link.fire(k, 8'h5a + 8'(k));
      wt(3);
      rd(A_LNK);
      chk(rv, ex[k]);
      chk(fault_rollup[4], 32'h1);
      chk(fault_out_n, 32'h0);
      if (k == 0 || k == 2) begin
        rd(k == 0 ? A_RSP : A_CMD);
        chk(rv, 8'h5a + k);
      end
      wr(A_CLR, 32'h1);
      wt(2);
      rd(A_LNK);
      chk(rv, 32'h0);
      rd(A_RSP);
      chk(rv, 32'h0);
      rd(A_CMD);
      chk(rv, 32'h0);
    end
    active_mode <= 0;
    sleep_mode <= 1;
    link.fire(5, 8'h00);
    wt(3);
    wr(A_CLR, 32'h0);
    rd(A_LNK);
    chk(rv, 32'h02);
    wr(A_MSK, 32'h8);
    wt(3);
    chk(fault_rollup[4], 32'h0);
    chk(fault_out_n, 32'h1);
    wr(A_MSK, 32'h0);
    wr(A_CLR, 32'h1);
    active_mode <= 1;
    sleep_mode <= 0;
  endtask
  task t_otp;
    @(posedge pclk);
    otp_fault_set <= 8'h1f;
    @(posedge pclk);
    otp_fault_set <= 8'h00;
    wt(3);
    chk(fault_rollup, 32'h20);
    wr(A_CLR, 32'h40);
    wt(2);
    rd(A_OTP);
    chk(rv, 32'h07);
    chk(fault_rollup, 32'h20);
    wr(A_MSK, 32'h4);
    wt(3);
    chk(fault_rollup, 32'h0);
  endtask
  task t_bus;
    rd(A_CLR);
    chk(rv, 32'h0);
    rd(16'h0010);
    chk(re, 32'h1);
    chk(rv, 32'h0);
    wr(A_ROL, 32'hff);
    chk(re, 32'h0);
    rd(A_ROL);
    chk(rv, 32'h0);
  endtask
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    group_faults = '0;
    otp_fault_set = '0;
    active_mode = 1;
    sleep_mode = 0;
    err_total = 0;
    cmp_count = 0;
    cycles = 0;
    wt(8);
    presetn <= 1;
    t_reset();
    t_groups();
    t_link();
    t_otp();
    t_bus();
    wrap_up;
  end
endmodule
`default_nettype wire
